// file: logic/rsr_remote_read.sv
`timescale 1ns/1ns
module rsr_remote_read #(
   parameter int TIMEOUT_CYCLES = rsr_pkg::TIMEOUT_CYCLES,
   parameter int PULSE_DIV = rsr_pkg::PULSE_CYCLES
) (
   input wire logic CLK,
   input wire logic SRST,
   // AXI4-Lite slave
   input wire logic [15:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [15:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // Sensor link, request side
   output logic LINK_REQ,
   output logic [2:0] LINK_CODE,
   output logic [2:0] LINK_SEL,
   output logic [1:0] LINK_PAIR,
   // Sensor link, reply side
   input wire logic LINK_RX_VALID,
   input wire logic [15:0] LINK_RX_DATA,
   input wire logic LINK_RX_PARITY,
   // Power pulse strobes, one per input pair
   output logic [2:0] POWER_PULSE,
   // Interrupt
   output logic IRQ
);

   localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

   generate
      if (TIMEOUT_CYCLES < 2) begin : g_bad_tmo
         $error("TIMEOUT_CYCLES must be at least 2");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      // Bus side
      logic aw_hold;
      logic w_hold;
      logic [15:0] waddr;
      logic [7:0] wbyte;
      logic wlane;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [7:0] rbyte;
      // Registers
      logic [2:0] cmd_code;
      logic [1:0] cmd_phase;
      logic read_parity_error;
      logic [7:0] sel_fs;
      logic [7:0] sel_third;
      logic [15:0] rd_buf;
      logic [rsr_pkg::IRQ_W-1:0] irq_stat;
      logic [rsr_pkg::IRQ_W-1:0] irq_en;
      // Sequencer
      rsr_pkg::rsr_state_t state;
      logic [2:0] link_code;
      logic [2:0] link_sel;
      logic [1:0] link_pair;
      logic [TW-1:0] tmo_cnt;
      logic [2:0] pulse;
   } rsr_state_rec_t;

   rsr_state_rec_t s_reg;
   rsr_state_rec_t s_next;

   logic pulse_tick;

   // Power pulse rate, fixes the sensor converter's sample rate
   rsr_pulse_div #(
      .DIV(PULSE_DIV)
   ) u_div (
      .clk(CLK),
      .srst(SRST),
      .tick(pulse_tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Map the raw reply into the read buffer layout
   function automatic logic [15:0] fmt_reply(
      input logic [2:0] code,
      input logic [2:0] sel,
      input logic [15:0] raw
   );
      logic [15:0] r;
      r = raw;
      if (code == rsr_pkg::CODE_CMD1) begin
         if (sel[2:1] == 2'b00) begin
            r = {7'h00, raw[7], raw[6:0], 1'b0};
         end else if (sel[2:1] == 2'b11) begin
            r = raw;
         end
      end else begin
         unique case (sel[2:1])
            2'b00: r = {{5{raw[10]}}, raw[10:0]};
            2'b01: r = {8'h00, raw[7:0]};
            2'b10: r = {raw[7:0], 8'h00};
            2'b11: r = raw;
         endcase
      end
      return r;
   endfunction

   // Selector that belongs to a phase code
   function automatic logic [2:0] pick_sel(
      input logic [1:0] phase,
      input logic [7:0] fs,
      input logic [7:0] third
   );
      logic [2:0] s;
      s = third[rsr_pkg::SEL_THIRD_LSB +: 3];
      if (phase == rsr_pkg::PHASE_FIRST) begin
         s = fs[rsr_pkg::SEL_FIRST_LSB +: 3];
      end else if (phase == rsr_pkg::PHASE_SECOND) begin
         s = fs[rsr_pkg::SEL_SECOND_LSB +: 3];
      end
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic aw_fire;
      logic w_fire;
      logic ar_fire;
      logic do_wr;
      logic wr_cmd;
      logic start;
      logic [2:0] new_code;
      logic [1:0] new_phase;
      logic perr_clr;
      logic perr_set;
      logic [rsr_pkg::IRQ_W-1:0] irq_set;
      logic [rsr_pkg::IRQ_W-1:0] irq_clr;
      logic par_bad;
      aw_fire = AWVALID && !s_reg.aw_hold && !s_reg.bvalid;
      w_fire = WVALID && !s_reg.w_hold && !s_reg.bvalid;
      ar_fire = ARVALID && !s_reg.rvalid;
      do_wr = s_reg.aw_hold && s_reg.w_hold && s_reg.wlane;
      wr_cmd = do_wr && (s_reg.waddr == rsr_pkg::ADDR_CMD);
      new_code = s_reg.wbyte[rsr_pkg::CMD_CODE_LSB +: 3];
      new_phase = s_reg.wbyte[rsr_pkg::CMD_PHASE_LSB +: 2];
      start = 1'b0;
      perr_clr = 1'b0;
      perr_set = 1'b0;
      irq_set = rsr_pkg::RST_IRQ;
      irq_clr = rsr_pkg::RST_IRQ;
      par_bad = ^{LINK_RX_DATA, LINK_RX_PARITY};
      s_next = s_reg;
      s_next.pulse = 3'h0;

      // Write address and data are taken in either order
      if (aw_fire) begin
         s_next.aw_hold = 1'b1;
         s_next.waddr = AWADDR;
      end
      if (w_fire) begin
         s_next.w_hold = 1'b1;
         s_next.wbyte = WDATA[7:0];
         s_next.wlane = WSTRB[0];
      end

      // Commit a write once both halves are in
      if (s_reg.aw_hold && s_reg.w_hold) begin
         s_next.aw_hold = 1'b0;
         s_next.w_hold = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = rsr_pkg::RESP_OKAY;
         unique case (s_reg.waddr)
            rsr_pkg::ADDR_CMD, rsr_pkg::ADDR_RD_HIGH,
            rsr_pkg::ADDR_RD_LOW, rsr_pkg::ADDR_SEL_THIRD,
            rsr_pkg::ADDR_SEL_FS, rsr_pkg::ADDR_IRQ_STATUS,
            rsr_pkg::ADDR_IRQ_ENABLE, rsr_pkg::ADDR_IRQ_CLEAR: begin
            end
            default: s_next.bresp = rsr_pkg::RESP_SLVERR;
         endcase
      end
      if (s_reg.bvalid && BREADY) begin
         s_next.bvalid = 1'b0;
      end

      // Register side effects of a write
      if (do_wr) begin
         if (s_reg.waddr == rsr_pkg::ADDR_SEL_FS) begin
            s_next.sel_fs = s_reg.wbyte & rsr_pkg::SEL_FS_MASK;
         end
         if (s_reg.waddr == rsr_pkg::ADDR_SEL_THIRD) begin
            s_next.sel_third = s_reg.wbyte;
         end
         if (s_reg.waddr == rsr_pkg::ADDR_IRQ_ENABLE) begin
            s_next.irq_en = s_reg.wbyte[rsr_pkg::IRQ_W-1:0];
         end
         if (s_reg.waddr == rsr_pkg::ADDR_IRQ_CLEAR) begin
            irq_clr = s_reg.wbyte[rsr_pkg::IRQ_W-1:0];
         end
      end

      // Command register: parity flag clear and command start
      if (wr_cmd) begin
         perr_clr = !s_reg.wbyte[rsr_pkg::CMD_READ_PARITY_ERROR_BIT];
         if (s_reg.state == rsr_pkg::ST_IDLE &&
             (new_code == rsr_pkg::CODE_CMD1 ||
              new_code == rsr_pkg::CODE_CMD2) &&
             new_phase != rsr_pkg::PHASE_NONE) begin
            start = 1'b1;
         end
      end

      // Transaction sequencer
      unique case (s_reg.state)
         rsr_pkg::ST_IDLE: begin
            if (start) begin
               s_next.cmd_code = new_code;
               s_next.cmd_phase = new_phase;
               s_next.link_code = new_code;
               s_next.link_pair = new_phase;
               s_next.link_sel = pick_sel(new_phase, s_reg.sel_fs,
                                          s_reg.sel_third);
               s_next.state = rsr_pkg::ST_SEND;
            end
         end
         rsr_pkg::ST_SEND: begin
            s_next.tmo_cnt = '0;
            s_next.state = rsr_pkg::ST_WAIT;
         end
         rsr_pkg::ST_WAIT: begin
            if (LINK_RX_VALID) begin
               s_next.rd_buf = fmt_reply(s_reg.link_code, s_reg.link_sel,
                                         LINK_RX_DATA);
               perr_set = par_bad;
               irq_set[rsr_pkg::IRQ_PERR_BIT] = par_bad;
               s_next.state = rsr_pkg::ST_DONE;
            end else if (s_reg.tmo_cnt == TW'(TIMEOUT_CYCLES - 1)) begin
               irq_set[rsr_pkg::IRQ_TIMEOUT_BIT] = 1'b1;
               s_next.state = rsr_pkg::ST_DONE;
            end else begin
               s_next.tmo_cnt = s_reg.tmo_cnt + 1'b1;
            end
         end
         rsr_pkg::ST_DONE: begin
            s_next.cmd_code = rsr_pkg::CODE_NONE;
            irq_set[rsr_pkg::IRQ_DONE_BIT] = 1'b1;
            s_next.state = rsr_pkg::ST_IDLE;
         end
      endcase

      // Sticky flags, a set in the same cycle beats a clear
      s_next.read_parity_error = perr_set || (s_reg.read_parity_error && !perr_clr);
      s_next.irq_stat = irq_set | (s_reg.irq_stat & ~irq_clr);

      // Power pulses only on enabled pairs
      if (pulse_tick) begin
         s_next.pulse =
            s_reg.sel_third[rsr_pkg::PAIR_ENABLE_LSB +: 3];
      end

      // Read channel
      if (s_reg.rvalid && RREADY) begin
         s_next.rvalid = 1'b0;
      end
      if (ar_fire) begin
         s_next.rvalid = 1'b1;
         s_next.rresp = rsr_pkg::RESP_OKAY;
         s_next.rbyte = rsr_pkg::RST_BYTE;
         unique case (ARADDR)
            rsr_pkg::ADDR_CMD: begin
               s_next.rbyte[rsr_pkg::CMD_READ_PARITY_ERROR_BIT] = s_reg.read_parity_error;
               s_next.rbyte[rsr_pkg::CMD_CODE_LSB +: 3] =
                  s_reg.cmd_code;
               s_next.rbyte[rsr_pkg::CMD_PHASE_LSB +: 2] = s_reg.cmd_phase;
            end
            rsr_pkg::ADDR_RD_HIGH: s_next.rbyte = s_reg.rd_buf[15:8];
            rsr_pkg::ADDR_RD_LOW: s_next.rbyte = s_reg.rd_buf[7:0];
            rsr_pkg::ADDR_SEL_THIRD: s_next.rbyte = s_reg.sel_third;
            rsr_pkg::ADDR_SEL_FS: s_next.rbyte = s_reg.sel_fs;
            rsr_pkg::ADDR_IRQ_STATUS: begin
               s_next.rbyte[rsr_pkg::IRQ_W-1:0] = s_reg.irq_stat;
            end
            rsr_pkg::ADDR_IRQ_ENABLE: begin
               s_next.rbyte[rsr_pkg::IRQ_W-1:0] = s_reg.irq_en;
            end
            rsr_pkg::ADDR_IRQ_CLEAR: begin
            end
            default: s_next.rresp = rsr_pkg::RESP_SLVERR;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge CLK) begin
      if (SRST) begin
         s_reg <= '0;
         s_reg.state <= rsr_pkg::ST_IDLE;
         s_reg.sel_fs <= rsr_pkg::RST_BYTE;
         s_reg.sel_third <= rsr_pkg::RST_BYTE;
         s_reg.rd_buf <= rsr_pkg::RST_WORD;
         s_reg.irq_stat <= rsr_pkg::RST_IRQ;
         s_reg.irq_en <= rsr_pkg::RST_IRQ;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   // Bus handshakes
   assign AWREADY = !s_reg.aw_hold && !s_reg.bvalid;
   assign WREADY = !s_reg.w_hold && !s_reg.bvalid;
   assign BVALID = s_reg.bvalid;
   assign BRESP = s_reg.bresp;
   assign ARREADY = !s_reg.rvalid;
   assign RVALID = s_reg.rvalid;
   assign RRESP = s_reg.rresp;
   assign RDATA = {24'h00_0000, s_reg.rbyte};

   // Link request strobe lasts the single send state
   assign LINK_REQ = (s_reg.state == rsr_pkg::ST_SEND);
   assign LINK_CODE = s_reg.link_code;
   assign LINK_SEL = s_reg.link_sel;
   assign LINK_PAIR = s_reg.link_pair;
   assign POWER_PULSE = s_reg.pulse;

   // Level interrupt from enabled sticky status
   assign IRQ = |(s_reg.irq_stat & s_reg.irq_en);

endmodule

// file: logic/rsr_pkg.sv
package rsr_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register indices; the byte address is four times the index
   localparam logic [15:0] IDX_CMD = 16'h00FC;
   localparam logic [15:0] IDX_RD_HIGH = 16'h2602;
   localparam logic [15:0] IDX_RD_LOW = 16'h2603;
   localparam logic [15:0] IDX_SEL_THIRD = 16'h2709;
   localparam logic [15:0] IDX_SEL_FIRST_SECOND = 16'h270A;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'h0100;
   localparam logic [15:0] IDX_IRQ_ENABLE = 16'h0101;
   localparam logic [15:0] IDX_IRQ_CLEAR = 16'h0102;

   // Byte addresses on the bus
   localparam logic [15:0] ADDR_CMD = {IDX_CMD[13:0], 2'b00};
   localparam logic [15:0] ADDR_RD_HIGH = {IDX_RD_HIGH[13:0], 2'b00};
   localparam logic [15:0] ADDR_RD_LOW = {IDX_RD_LOW[13:0], 2'b00};
   localparam logic [15:0] ADDR_SEL_THIRD = {IDX_SEL_THIRD[13:0], 2'b00};
   localparam logic [15:0] ADDR_SEL_FS = {IDX_SEL_FIRST_SECOND[13:0], 2'b00};
   localparam logic [15:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS[13:0], 2'b00};
   localparam logic [15:0] ADDR_IRQ_ENABLE = {IDX_IRQ_ENABLE[13:0], 2'b00};
   localparam logic [15:0] ADDR_IRQ_CLEAR = {IDX_IRQ_CLEAR[13:0], 2'b00};

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CMD_CODE_LSB = 2;
   localparam int CMD_PHASE_LSB = 0;
   localparam int CMD_READ_PARITY_ERROR_BIT = 6;
   localparam int SEL_FIRST_LSB = 0;
   localparam int SEL_SECOND_LSB = 4;
   localparam int SEL_THIRD_LSB = 0;
   localparam int PAIR_ENABLE_LSB = 3;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_PERR_BIT = 1;
   localparam int IRQ_TIMEOUT_BIT = 2;
   localparam int IRQ_W = 3;

   // Reset values and masks
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;
   localparam logic [7:0] SEL_FS_MASK = 8'h77;

   ////////////////////////////////////////////////////////////////////////
   // Command and phase codes
   localparam logic [2:0] CODE_CMD1 = 3'h1;
   localparam logic [2:0] CODE_CMD2 = 3'h2;
   localparam logic [2:0] CODE_NONE = 3'h0;
   localparam logic [1:0] PHASE_NONE = 2'h0;
   localparam logic [1:0] PHASE_FIRST = 2'h1;
   localparam logic [1:0] PHASE_SECOND = 2'h2;
   localparam logic [1:0] PHASE_THIRD = 2'h3;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int PULSE_PERIOD_NS = 1000;
   localparam int PULSE_CYCLES = PULSE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TIMEOUT_US = 100;
   localparam int TIMEOUT_CYCLES = TIMEOUT_US * 1000 / CLK_PERIOD_NS;

   // Transaction sequencer, Gray along the usual path
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01,
      ST_WAIT = 2'b11,
      ST_DONE = 2'b10
   } rsr_state_t;

endpackage

// file: logic/rsr_pulse_div.sv
`timescale 1ns/1ns
module rsr_pulse_div #(
   parameter int DIV = rsr_pkg::PULSE_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   output logic tick
);

   localparam int CW = $clog2(DIV);

   generate
      if (DIV < 2) begin : g_bad
         $error("rsr_pulse_div needs DIV of at least 2");
      end
   endgenerate

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic tick;
   } rsr_div_t;

   rsr_div_t s_reg;
   rsr_div_t s_next;

   // Count down one period, strobe at wrap
   always_comb begin
      s_next = s_reg;
      s_next.tick = 1'b0;
      if (s_reg.cnt == '0) begin
         s_next.cnt = CW'(DIV - 1);
         s_next.tick = 1'b1;
      end else begin
         s_next.cnt = s_reg.cnt - 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick = s_reg.tick;

endmodule

// file: verif/rsr_remote_read_assertions.sv
`timescale 1ns/1ns
module rsr_chk #(
   parameter int PULSE_DIV = rsr_pkg::PULSE_CYCLES
) (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic RVALID,
   input wire logic RREADY,
   input wire logic [31:0] RDATA,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic [1:0] BRESP,
   input wire logic AWREADY,
   input wire logic WREADY,
   input wire logic LINK_REQ,
   input wire logic [2:0] LINK_CODE,
   input wire logic [2:0] LINK_SEL,
   input wire logic [1:0] LINK_PAIR,
   input wire logic LINK_RX_VALID,
   input wire logic [2:0] POWER_PULSE
);
   logic wait_reg;
   logic seen_reg;
   int gap_reg;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   // Outstanding sensor read and cycles since the last power pulse
   always_ff @(posedge CLK) begin
      if (SRST) begin
         wait_reg <= 1'b0;
         seen_reg <= 1'b0;
         gap_reg <= 0;
      end else begin
         wait_reg <= LINK_REQ || (wait_reg && !LINK_RX_VALID);
         seen_reg <= seen_reg || (|POWER_PULSE);
         gap_reg <= (|POWER_PULSE) ? 1 : gap_reg + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////
   req_pulse_a: assert property (LINK_REQ |=> !LINK_REQ)
      else $error("link request wider than one cycle");
   req_code_a: assert property (LINK_REQ |-> LINK_PAIR != 2'h0 &&
      (LINK_CODE == 3'h1 || LINK_CODE == 3'h2))
      else $error("link request with unusable code or phase");
   busy_drop_a: assert property (wait_reg |-> !LINK_REQ)
      else $error("new link request while a read is outstanding");
   fields_hold_a: assert property (!LINK_REQ |->
      $stable({LINK_CODE, LINK_SEL, LINK_PAIR}))
      else $error("link fields moved without a request");
   read_lat_a: assert property (ARVALID && ARREADY |=> RVALID)
      else $error("read answer late");
   read_hold_a: assert property (RVALID && !RREADY |=>
      RVALID && $stable(RDATA))
      else $error("read data dropped before taken");
   read_zero_a: assert property (RVALID |-> RDATA[31:8] == '0)
      else $error("upper read bits not zero");
   write_hold_a: assert property (BVALID && !BREADY |=>
      BVALID && $stable(BRESP))
      else $error("write response dropped before taken");
   bus_block_a: assert property (BVALID |-> !AWREADY && !WREADY)
      else $error("write channels open while response pending");
   pulse_gap_a: assert property ((|POWER_PULSE) && seen_reg |->
      gap_reg == PULSE_DIV)
      else $error("power pulse spacing wrong");
endmodule

bind rsr_remote_read rsr_chk #(.PULSE_DIV(PULSE_DIV)) i_chk (
   .CLK(CLK), .SRST(SRST), .ARVALID(ARVALID), .ARREADY(ARREADY),
   .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .BVALID(BVALID),
   .BREADY(BREADY), .BRESP(BRESP), .AWREADY(AWREADY), .WREADY(WREADY),
   .LINK_REQ(LINK_REQ), .LINK_CODE(LINK_CODE), .LINK_SEL(LINK_SEL),
   .LINK_PAIR(LINK_PAIR), .LINK_RX_VALID(LINK_RX_VALID),
   .POWER_PULSE(POWER_PULSE));

// file: verif/rsr_sensor_model.sv
`timescale 1ns/1ns
module rsr_sensor_model (
   input wire logic clk,
   input wire logic srst,
   input wire logic req,
   input wire logic [15:0] raw,
   input wire logic [7:0] dly,
   input wire logic bad,
   output logic rx_valid,
   output logic [15:0] rx_data,
   output logic rx_parity
);
   logic [7:0] cnt = 8'h00;
   // Idle lines start known so their toggling stays defined
   initial begin
      rx_valid = 1'b0;
      rx_data = 16'h0000;
      rx_parity = 1'b0;
   end
   // Answer each request after dly cycles; between replies the lines toggle
   always @(posedge clk) begin
      if (srst) cnt <= 8'h00;
      else if (req) cnt <= dly;
      else if (cnt != 8'h00) cnt <= cnt - 8'h01;
      rx_valid <= !srst && cnt == 8'h01;
      rx_data <= (cnt == 8'h01) ? raw : ~rx_data;
      rx_parity <= (cnt == 8'h01) ? (^raw) ^ bad : ~rx_parity;
   end
endmodule

// file: verif/rsr_remote_read_bench.sv
`timescale 1ns/1ns
module rsr_remote_read_bench;
   localparam int DIV = 4;
   localparam logic [1:0] OK = rsr_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = rsr_pkg::RESP_SLVERR;
   logic CLK = 1'b0;
   logic SRST = 1'b1;
   logic [15:0] AWADDR = 16'h0000;
   logic [15:0] ARADDR = 16'h0000;
   logic [31:0] WDATA = 32'h0000_0000;
   logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
   logic ARVALID = 1'b0, RREADY = 1'b0;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, LINK_REQ, IRQ;
   logic [1:0] BRESP, RRESP, LINK_PAIR;
   logic [31:0] RDATA;
   logic [2:0] LINK_CODE, LINK_SEL, POWER_PULSE;
   logic LINK_RX_VALID, LINK_RX_PARITY;
   logic [15:0] LINK_RX_DATA;
   logic [15:0] raw = 16'h0000;
   logic [7:0] dly = 8'h06;
   logic bad = 1'b0, perr = 1'b0;
   int failures = 0;
   int n_checks = 0;
   int pulses = 0;
   logic [15:0] last = 16'h0000;
   logic [33:0] link_got;
   assign link_got = 34'({LINK_CODE, LINK_SEL, LINK_PAIR});
   logic [33:0] bq[$];
   logic [33:0] rq[$];
   logic [33:0] lq[$];

   rsr_remote_read #(.TIMEOUT_CYCLES(20), .PULSE_DIV(DIV)) i_dut (
      .CLK(CLK), .SRST(SRST), .AWADDR(AWADDR), .AWVALID(AWVALID),
      .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID),
      .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
      .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
      .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
      .LINK_REQ(LINK_REQ), .LINK_CODE(LINK_CODE), .LINK_SEL(LINK_SEL),
      .LINK_PAIR(LINK_PAIR), .LINK_RX_VALID(LINK_RX_VALID),
      .LINK_RX_DATA(LINK_RX_DATA), .LINK_RX_PARITY(LINK_RX_PARITY),
      .POWER_PULSE(POWER_PULSE), .IRQ(IRQ));
   rsr_sensor_model i_sensor (.clk(CLK), .srst(SRST), .req(LINK_REQ),
      .raw(raw), .dly(dly), .bad(bad), .rx_valid(LINK_RX_VALID),
      .rx_data(LINK_RX_DATA), .rx_parity(LINK_RX_PARITY));

   // Clock
   initial begin
      forever #5 CLK = ~CLK;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results;
      if (failures == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Write: address and data together, each released when taken;
   // the response is left waiting a cycle before it is accepted
   task automatic wr(input logic [15:0] a, input logic [7:0] d,
                     input logic [1:0] r);
      bq.push_back(34'(r));
      AWADDR <= a;
      WDATA <= {24'h00_0000, d};
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      @(posedge CLK);
      while (AWVALID || WVALID) begin
         if (AWREADY) AWVALID <= 1'b0;
         if (WREADY) WVALID <= 1'b0;
         @(posedge CLK);
      end
      while (!BVALID) @(posedge CLK);
      BREADY <= 1'b1;
      @(posedge CLK);
      BREADY <= 1'b0;
      @(posedge CLK);
   endtask
   // Read: the data is left waiting a cycle before it is accepted
   task automatic rd(input logic [15:0] a, input logic [7:0] e,
                     input logic [1:0] r);
      rq.push_back({r, 24'h00_0000, e});
      ARADDR <= a;
      ARVALID <= 1'b1;
      @(posedge CLK);
      while (!ARREADY) @(posedge CLK);
      ARVALID <= 1'b0;
      @(posedge CLK);
      RREADY <= 1'b1;
      @(posedge CLK);
      while (!RVALID) @(posedge CLK);
      RREADY <= 1'b0;
      @(posedge CLK);
   endtask
   function automatic logic [15:0] fmt(input logic [2:0] c,
      input logic [1:0] s, input logic [15:0] r);
      if (c == 3'h1 && s == 2'h0) return {7'h00, r[7:0], 1'b0};
      if (c == 3'h2 && s == 2'h0) return {{5{r[10]}}, r[10:0]};
      if (c == 3'h2 && s == 2'h1) return {8'h00, r[7:0]};
      if (c == 3'h2 && s == 2'h2) return {r[7:0], 8'h00};
      return r;
   endfunction
   // One sensor read, a dropped command while busy, then readout
   task automatic xact(input logic [2:0] c, input logic [1:0] p,
                       input logic [2:0] s, input logic b);
      logic [15:0] e;
      raw = 16'($urandom);
      dly = 8'($urandom_range(6, 14));
      bad = b;
      perr = perr | b;
      e = fmt(c, s[2:1], raw);
      last = e;
      if (p == 2'h3) begin
         wr(rsr_pkg::ADDR_SEL_THIRD, {2'h0, 3'h7, s}, OK);
      end else begin
         wr(rsr_pkg::ADDR_SEL_FS, {1'b0, s, 1'b0, s}, OK);
      end
      lq.push_back(34'({c, s, p}));
      // No compute engine runs here, so any moment suits the command
      wr(rsr_pkg::ADDR_CMD, {3'h2, c, p}, OK);
      wr(rsr_pkg::ADDR_CMD, 8'h4b, OK);
      while (!IRQ) @(posedge CLK);
      rd(rsr_pkg::ADDR_CMD, {1'b0, perr, 4'h0, p}, OK);
      rd(rsr_pkg::ADDR_RD_HIGH, e[15:8], OK);
      rd(rsr_pkg::ADDR_RD_LOW, e[7:0], OK);
      rd(rsr_pkg::ADDR_IRQ_STATUS, {6'h00, perr, 1'b1}, OK);
      wr(rsr_pkg::ADDR_IRQ_CLEAR, 8'h01, OK);
      chk(34'(IRQ), 34'h0);
   endtask

   // Results as they appear, against the oldest note
   always @(posedge CLK) begin
      if (BVALID && BREADY) chk(34'(BRESP), bq.pop_front());
      if (RVALID && RREADY) chk({RRESP, RDATA}, rq.pop_front());
      if (LINK_REQ) chk(link_got, lq.pop_front());
      if (|POWER_PULSE) pulses++;
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge CLK);
      failures++;
      results();
   end
   // Main sequence
   initial begin
      logic [7:0] inv[3];
      logic [15:0] ra[6];
      inv = '{8'h55, 8'h41, 8'h44};
      ra = '{rsr_pkg::ADDR_CMD, rsr_pkg::ADDR_RD_HIGH, rsr_pkg::ADDR_RD_LOW,
             rsr_pkg::ADDR_SEL_THIRD, rsr_pkg::ADDR_SEL_FS,
             rsr_pkg::ADDR_IRQ_STATUS};
      void'($urandom(32'h2db5));
      repeat (6) @(posedge CLK);
      SRST <= 1'b0;
      @(posedge CLK);
      foreach (ra[i]) rd(ra[i], 8'h00, OK);
      rd(16'h0008, 8'h00, ERR);
      wr(16'h0008, 8'h5a, ERR);
      wr(rsr_pkg::ADDR_SEL_FS, 8'hff, OK);
      rd(rsr_pkg::ADDR_SEL_FS, 8'h77, OK);
      wr(rsr_pkg::ADDR_RD_HIGH, 8'ha5, OK);
      rd(rsr_pkg::ADDR_RD_HIGH, 8'h00, OK);
      wr(rsr_pkg::ADDR_IRQ_ENABLE, 8'h01, OK);
      rd(rsr_pkg::ADDR_IRQ_ENABLE, 8'h01, OK);
      xact(3'h1, 2'h1, {2'h0, 1'($urandom)}, 1'b0);
      xact(3'h1, 2'h2, {2'h3, 1'($urandom)}, 1'b0);
      xact(3'h2, 2'h3, {2'h0, 1'($urandom)}, 1'b1);
      xact(3'h2, 2'h1, {2'h1, 1'($urandom)}, 1'b0);
      xact(3'h2, 2'h2, {2'h2, 1'($urandom)}, 1'b0);
      // A silent sensor times out; its late reply must not land
      wr(rsr_pkg::ADDR_SEL_FS, 8'h00, OK);
      lq.push_back(34'({3'h2, 3'h0, 2'h1}));
      dly = 8'h28;
      wr(rsr_pkg::ADDR_CMD, 8'h49, OK);
      while (!IRQ) @(posedge CLK);
      rd(rsr_pkg::ADDR_IRQ_STATUS, 8'h07, OK);
      rd(rsr_pkg::ADDR_CMD, 8'h41, OK);
      repeat (30) @(posedge CLK);
      rd(rsr_pkg::ADDR_RD_HIGH, last[15:8], OK);
      rd(rsr_pkg::ADDR_RD_LOW, last[7:0], OK);
      wr(rsr_pkg::ADDR_IRQ_CLEAR, 8'h05, OK);
      // Parity status was masked until enabled, then cleared
      wr(rsr_pkg::ADDR_IRQ_ENABLE, 8'h02, OK);
      chk(34'(IRQ), 34'h1);
      wr(rsr_pkg::ADDR_CMD, 8'h00, OK);
      rd(rsr_pkg::ADDR_CMD, 8'h01, OK);
      wr(rsr_pkg::ADDR_IRQ_CLEAR, 8'h02, OK);
      chk(34'(IRQ), 34'h0);
      // Ignored codes and the unusable phase start nothing
      foreach (inv[i]) begin
         wr(rsr_pkg::ADDR_CMD, inv[i], OK);
         repeat (30) @(posedge CLK);
         rd(rsr_pkg::ADDR_CMD, 8'h01, OK);
      end
      chk(34'(pulses > 20), 34'h1);
      chk(34'(lq.size() + rq.size() + bq.size()), 34'h0);
      results();
   end
endmodule
